// file: logic/mctf_defines.svh
// Register offsets, field positions, reset values and timing constants of the throttle filter.
`ifndef MCTF_DEFINES_SVH
`define MCTF_DEFINES_SVH

// Byte addresses of the 32-bit register words.
`define MCTF_OFS_CMD_WEIGHTS      12'h1c0
`define MCTF_OFS_CTRL_THROTTLE    12'h1c4
`define MCTF_OFS_PASSIVE_LO       12'h1c8
`define MCTF_OFS_PASSIVE_HI       12'h1cc
`define MCTF_OFS_ACTIVE_LO        12'h1d0
`define MCTF_OFS_ACTIVE_HI        12'h1d4
`define MCTF_OFS_RANK_THROTTLE    12'h1d8
`define MCTF_OFS_OBSERVATION      12'h1dc

// Reset values of the stored words.
`define MCTF_RST_WORD             32'h0000_0000
`define MCTF_RST_SEL              3'h0

// Writable bits of the control words and of the passive high word.
`define MCTF_CTRL_WMASK           32'ha1f7_ffff
`define MCTF_PASSIVE_HI_WMASK     32'h0000_ffff

// Field positions inside the control words.
`define MCTF_LOCK_BIT             31
`define MCTF_BW_EN_BIT            21
`define MCTF_THERM_EN_BIT         20
`define MCTF_TC_MSB               18
`define MCTF_TC_LSB               16
`define MCTF_BW_THR_MSB           15
`define MCTF_BW_THR_LSB           8
`define MCTF_TH_THR_MSB           7
`define MCTF_TH_THR_LSB           0

// Observation selector codes.
`define MCTF_OBS_CTRL             3'h0
`define MCTF_OBS_RANK0            3'h1
`define MCTF_OBS_RANK1            3'h2

// Log2 of the shortest averaging window, in clocks.
`define MCTF_TC_BASE_LOG2         28

`endif

// file: logic/mctf_pkg.sv
// Types shared by the throttle filter modules.
`default_nettype none
package mctf_pkg;

	// Command on the channel's command bus in the present clock.
	typedef enum logic [3:0] {
		CMD_RD_AP,
		CMD_WR_AP,
		CMD_RD,
		CMD_WR,
		CMD_PRE_ALL,
		CMD_PRE,
		CMD_ACT,
		CMD_REF,
		CMD_OTHER
	} mctf_cmd_e;

	// Command issued this clock, with its valid flag and rank selects.
	typedef struct packed {
		logic      valid;
		mctf_cmd_e kind;
		logic [1:0] chipSel;
	} mctf_cmd_s;

	// Power and page state of one rank in the present clock.
	typedef struct packed {
		logic powerDown;
		logic pageOpen;
		logic selfRefresh;
		logic odt;
	} mctf_rank_s;

	// Eight-bit weight and filter average.
	typedef logic [7:0] mctf_byte_t;

endpackage

`default_nettype wire

// file: logic/mctf_avg_filter.sv
// Exponential averaging filter with a selectable power-of-two window.
`timescale 1ns/1ps
`default_nettype none
`include "mctf_defines.svh"

module mctf_avg_filter
	import mctf_pkg::*;
#(
	parameter int TC_BASE = `MCTF_TC_BASE_LOG2,
	parameter int WW      = 10
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          ce,
	input  wire logic [WW-1:0] weight,
	input  wire logic [1:0]    tcSel,
	output var  mctf_byte_t    avg
);

	// Accumulator holds the average scaled up by the window length.
	localparam int ACCW = WW + TC_BASE + 4;

	logic [ACCW-1:0] acc_ff;     // Scaled running sum.
	logic [ACCW-1:0] nxt_acc;    // Next scaled running sum.
	logic [ACCW-1:0] scaled;     // Present average, unscaled.
	logic [5:0]      shiftAmt;   // Window log2 for this setting.

	// Window doubles with each step of the time-constant code.
	always_comb begin
		shiftAmt = 6'(TC_BASE) + {4'h0, tcSel};
		scaled   = acc_ff >> shiftAmt;
		nxt_acc  = acc_ff + ACCW'(weight) - scaled;
	end

	// Each clock the new weight enters and one window share leaves.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_ff <= '0;
		end else if (ce) begin
			acc_ff <= nxt_acc;
		end
	end

	// The average saturates at the top of the eight-bit range.
	always_comb begin
		if (scaled > ACCW'(8'hff)) begin
			avg = 8'hff;
		end else begin
			avg = scaled[7:0];
		end
	end

endmodule

`default_nettype wire

// file: logic/mctf_throttle.sv
// Throttle filter for the second memory channel: registers, weights, filters and hold-off.
//
// Operation
// - Valid read feeds read weight to controller filter.
// - Valid write feeds write weight to controller filter.
// - Other valid command feeds other-command weight.
// - No command feeds idle weight.
// - Controller lock resets zero, then freezes configuration.
// - Bandwidth enable gates bandwidth threshold throttling.
// - Thermal trip with both enabled uses thermal threshold.
// - Thermal enable plus trip throttles at threshold.
// - Bandwidth mode holds commands when average reaches threshold.
// - Thermal mode holds commands when average reaches threshold.
// - Asserted termination adds termination weight to rank.
// - Active rank feeds open-page or precharged active weight.
// - Powered-down rank feeds open-page or precharged powerdown weight.
// - Self-refresh rank feeds self-refresh weight.
// - Passive weights locked by first channel rank lock.
// - Chip-selected command adds its active weight.
// - Observation selector picks controller or rank average.
// - Observation returns selected average and throttle signals.
// - Time-constant code selects window of 2^28..2^31 clocks.
// - Rank lock resets zero, then freezes rank registers.
`timescale 1ns/1ps
`default_nettype none
`include "mctf_defines.svh"

module mctf_throttle
	import mctf_pkg::*;
#(
	parameter int NUM_RANKS = 2,
	parameter int TC_BASE   = `MCTF_TC_BASE_LOG2
) (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    ce,
	input  wire logic [11:0]             regAddr,
	input  wire logic [31:0]             regWrData,
	input  wire logic                    regWrEn,
	input  wire logic                    regRdEn,
	output logic [31:0]                  regRdData,
	input  wire mctf_cmd_s               cmdBus,
	input  wire mctf_rank_s [1:0]        rankState,
	input  wire logic                    thermalTrip,
	input  wire logic                    firstChanRankLock,
	output logic                         holdCommands
);

	// Stored register words.
	logic [31:0] cmdWeights_ff;     // Controller command event weights.
	logic [31:0] ctrlThrottle_ff;   // Controller throttle control.
	logic [31:0] passiveLo_ff;      // Rank passive weights, low word.
	logic [31:0] passiveHi_ff;      // Rank passive weights, high word.
	logic [31:0] activeLo_ff;       // Rank active weights, low word.
	logic [31:0] activeHi_ff;       // Rank active weights, high word.
	logic [31:0] rankThrottle_ff;   // Rank throttle control.
	logic [2:0]  obsSel_ff;         // Observation average selector.
	logic [31:0] rdData_ff;         // Read data, valid the cycle after a read.
	logic        hold_ff;           // Registered hold-off of new commands.

	// Decoded controls.
	logic        ctrlLocked;        // Controller registers frozen.
	logic        rankLocked;        // Rank registers frozen.
	logic        passiveLocked;     // Passive weights frozen.
	logic [1:0]  tcSel;             // Averaging window code.
	logic        bwEnable;          // Bandwidth throttling enabled.
	logic        thermEnable;       // Thermal trip throttling enabled.
	mctf_byte_t  bwThreshold;       // Bandwidth threshold.
	mctf_byte_t  thermThreshold;    // Thermal threshold.

	// Filter inputs and outputs.
	logic [9:0]  ctrlWeight;                  // Controller filter input.
	logic [9:0]  rankWeight [NUM_RANKS];      // Per-rank filter inputs.
	mctf_byte_t  ctrlAvg;                     // Controller filter average.
	mctf_byte_t  rankAvg [NUM_RANKS];         // Per-rank averages.
	logic        bwHit;                       // Average at or above bandwidth threshold.
	logic        thermHit;                    // Average at or above thermal threshold.
	logic        nxt_hold;                    // Next hold-off state.
	mctf_byte_t  selAvg;                      // Average picked by the selector.
	logic [31:0] nxt_rdData;                  // Read data for the next cycle.

	// Returns the active weight of a command type from the 64-bit active word.
	function automatic mctf_byte_t active_weight(input mctf_cmd_e kind,
		input logic [63:0] w);
		begin
			case (kind)
				CMD_RD_AP:   active_weight = w[63:56];
				CMD_WR_AP:   active_weight = w[55:48];
				CMD_RD:      active_weight = w[47:40];
				CMD_WR:      active_weight = w[39:32];
				CMD_PRE_ALL: active_weight = w[31:24];
				CMD_PRE:     active_weight = w[23:16];
				CMD_ACT:     active_weight = w[15:8];
				CMD_REF:     active_weight = w[7:0];
				default:     active_weight = 8'h00;
			endcase
		end
	endfunction

	// Merges a write into a word, touching only the writable bits.
	function automatic logic [31:0] merge_write(input logic [31:0] old,
		input logic [31:0] data, input logic [31:0] mask);
		begin
			merge_write = (old & ~mask) | (data & mask);
		end
	endfunction

	// Lock bits and configuration fields.
	always_comb begin
		ctrlLocked     = ctrlThrottle_ff[`MCTF_LOCK_BIT];
		rankLocked     = rankThrottle_ff[`MCTF_LOCK_BIT];
		passiveLocked  = rankLocked | firstChanRankLock;
		tcSel          = rankThrottle_ff[`MCTF_TC_LSB+1:`MCTF_TC_LSB];
		bwEnable       = ctrlThrottle_ff[`MCTF_BW_EN_BIT];
		thermEnable    = ctrlThrottle_ff[`MCTF_THERM_EN_BIT];
		bwThreshold    = ctrlThrottle_ff[`MCTF_BW_THR_MSB:`MCTF_BW_THR_LSB];
		thermThreshold = ctrlThrottle_ff[`MCTF_TH_THR_MSB:`MCTF_TH_THR_LSB];
	end

	// Controller registers: writes are ignored once the controller lock is set.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmdWeights_ff   <= `MCTF_RST_WORD;
			ctrlThrottle_ff <= `MCTF_RST_WORD;
		end else if (ce && regWrEn && !ctrlLocked) begin
			// Writes land only while the lock is still clear.
			if (regAddr == `MCTF_OFS_CMD_WEIGHTS) begin
				cmdWeights_ff <= regWrData;
			end
			if (regAddr == `MCTF_OFS_CTRL_THROTTLE) begin
				ctrlThrottle_ff <= merge_write(ctrlThrottle_ff, regWrData,
					`MCTF_CTRL_WMASK);
			end
		end
	end

	// Passive weights: frozen by either channel's rank lock.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			passiveLo_ff <= `MCTF_RST_WORD;
			passiveHi_ff <= `MCTF_RST_WORD;
		end else if (ce && regWrEn && !passiveLocked) begin
			// The top sixteen bits of the high word stay zero.
			if (regAddr == `MCTF_OFS_PASSIVE_LO) begin
				passiveLo_ff <= regWrData;
			end
			if (regAddr == `MCTF_OFS_PASSIVE_HI) begin
				passiveHi_ff <= merge_write(passiveHi_ff, regWrData,
					`MCTF_PASSIVE_HI_WMASK);
			end
		end
	end

	// Active weights and rank control: frozen by this channel's rank lock.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			activeLo_ff     <= `MCTF_RST_WORD;
			activeHi_ff     <= `MCTF_RST_WORD;
			rankThrottle_ff <= `MCTF_RST_WORD;
		end else if (ce && regWrEn && !rankLocked) begin
			// Once the lock bit is written high no further write lands.
			if (regAddr == `MCTF_OFS_ACTIVE_LO) begin
				activeLo_ff <= regWrData;
			end
			if (regAddr == `MCTF_OFS_ACTIVE_HI) begin
				activeHi_ff <= regWrData;
			end
			if (regAddr == `MCTF_OFS_RANK_THROTTLE) begin
				rankThrottle_ff <= merge_write(rankThrottle_ff, regWrData,
					`MCTF_CTRL_WMASK);
			end
		end
	end

	// Observation selector: plain read/write, never locked.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			obsSel_ff <= `MCTF_RST_SEL;
		end else if (ce && regWrEn && regAddr == `MCTF_OFS_OBSERVATION) begin
			obsSel_ff <= regWrData[`MCTF_TC_MSB:`MCTF_TC_LSB];
		end
	end

	// Controller filter input follows the command bus each clock.
	always_comb begin
		if (!cmdBus.valid) begin
			ctrlWeight = {2'b00, cmdWeights_ff[7:0]};
		end else begin
			case (cmdBus.kind)
				// Reads with or without auto precharge count as reads.
				CMD_RD, CMD_RD_AP: begin
					ctrlWeight = {2'b00, cmdWeights_ff[31:24]};
				end
				// Writes with or without auto precharge count as writes.
				CMD_WR, CMD_WR_AP: begin
					ctrlWeight = {2'b00, cmdWeights_ff[23:16]};
				end
				// Any other command.
				default: begin
					ctrlWeight = {2'b00, cmdWeights_ff[15:8]};
				end
			endcase
		end
	end

	// Per-rank weight: state weight, plus termination and command shares.
	generate
		for (genvar r = 0; r < NUM_RANKS; r++) begin : g_rank
			mctf_byte_t stateW;   // Power-state weight of the rank.
			mctf_byte_t odtW;     // Termination share.
			mctf_byte_t cmdW;     // Command share when chip-selected.

			// Self refresh outranks power down, which outranks active.
			always_comb begin
				if (rankState[r].selfRefresh) begin
					stateW = passiveLo_ff[7:0];
				end else if (rankState[r].powerDown) begin
					stateW = rankState[r].pageOpen ? passiveLo_ff[23:16]
						: passiveLo_ff[15:8];
				end else begin
					stateW = rankState[r].pageOpen ? passiveHi_ff[7:0]
						: passiveLo_ff[31:24];
				end
			end

			// Termination weight is added while termination is on.
			always_comb begin
				odtW = rankState[r].odt ? passiveHi_ff[15:8] : 8'h00;
			end

			// A command to this rank adds the weight of its type.
			always_comb begin
				if (cmdBus.valid && cmdBus.chipSel[r]) begin
					cmdW = active_weight(cmdBus.kind, {activeHi_ff, activeLo_ff});
				end else begin
					cmdW = 8'h00;
				end
			end

			// The three shares sum in ten bits so nothing wraps.
			always_comb begin
				rankWeight[r] = {2'b00, stateW} + {2'b00, odtW} + {2'b00, cmdW};
			end

			// Rank averaging filter.
			mctf_avg_filter #(
				.TC_BASE (TC_BASE),
				.WW      (10)
			) u_rank_filter (
				.clk     (clk),
				.sys_rst (sys_rst),
				.ce      (ce),
				.weight  (rankWeight[r]),
				.tcSel   (tcSel),
				.avg     (rankAvg[r])
			);
		end
	endgenerate

	// Controller averaging filter shares the rank window setting.
	mctf_avg_filter #(
		.TC_BASE (TC_BASE),
		.WW      (10)
	) u_ctrl_filter (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.weight  (ctrlWeight),
		.tcSel   (tcSel),
		.avg     (ctrlAvg)
	);

	// Threshold comparisons against the controller average.
	always_comb begin
		bwHit    = ctrlAvg >= bwThreshold;
		thermHit = ctrlAvg >= thermThreshold;
	end

	// Mode choice: a tripped, enabled sensor switches to the thermal threshold.
	always_comb begin
		if (thermEnable && thermalTrip) begin
			nxt_hold = thermHit;
		end else if (bwEnable) begin
			nxt_hold = bwHit;
		end else begin
			nxt_hold = 1'b0;
		end
	end

	// Hold-off flag: the scheduler keeps commands pending while it is high.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_ff <= 1'b0;
		end else if (ce) begin
			hold_ff <= nxt_hold;
		end
	end

	// Average shown in the observation word.
	always_comb begin
		case (obsSel_ff)
			`MCTF_OBS_CTRL:  selAvg = ctrlAvg;
			`MCTF_OBS_RANK0: selAvg = rankAvg[0];
			`MCTF_OBS_RANK1: selAvg = rankAvg[NUM_RANKS-1];
			default:         selAvg = 8'h00;
		endcase
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		case (regAddr)
			`MCTF_OFS_CMD_WEIGHTS:   nxt_rdData = cmdWeights_ff;
			`MCTF_OFS_CTRL_THROTTLE: nxt_rdData = ctrlThrottle_ff;
			`MCTF_OFS_PASSIVE_LO:    nxt_rdData = passiveLo_ff;
			`MCTF_OFS_PASSIVE_HI:    nxt_rdData = passiveHi_ff;
			`MCTF_OFS_ACTIVE_LO:     nxt_rdData = activeLo_ff;
			`MCTF_OFS_ACTIVE_HI:     nxt_rdData = activeHi_ff;
			`MCTF_OFS_RANK_THROTTLE: nxt_rdData = rankThrottle_ff;
			// Selector, selected average and live throttle signals.
			`MCTF_OFS_OBSERVATION: begin
				nxt_rdData = {13'h0000, obsSel_ff, selAvg,
					5'h00, thermHit, bwHit, hold_ff};
			end
			default: nxt_rdData = 32'h0000_0000;
		endcase
	end

	// Read data stands for one cycle after the read strobe, zero otherwise.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData_ff <= 32'h0000_0000;
		end else if (ce) begin
			rdData_ff <= regRdEn ? nxt_rdData : 32'h0000_0000;
		end
	end

	// Outputs come straight from flip-flops.
	assign regRdData    = rdData_ff;
	assign holdCommands = hold_ff;

endmodule

`default_nettype wire

// file: verification/mctf_rank_model.sv
// Model of the two ranks that report page and power state.
`timescale 1ns/1ps
`default_nettype none

module mctf_rank_model
	import mctf_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire mctf_cmd_s       cmdBus,
	input  wire logic [1:0]      pdReq,
	input  wire logic [1:0]      srReq,
	input  wire logic [1:0]      odtReq,
	output var  mctf_rank_s [1:0] rankState
);
	logic [1:0] pageOpen_ff; // A row is open in the rank.

	// Activate opens a row; any precharge closes all rows.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pageOpen_ff <= 2'h0;
		end else begin
			for (int r = 0; r < 2; r++) begin
				if (cmdBus.valid && cmdBus.chipSel[r]) begin
					if (cmdBus.kind == CMD_ACT) pageOpen_ff[r] <= 1'b1;
					else if (cmdBus.kind inside {CMD_PRE, CMD_PRE_ALL, CMD_RD_AP, CMD_WR_AP})
						pageOpen_ff[r] <= 1'b0;
				end
			end
		end
	end

	// Power and termination follow the request pins.
	always_comb begin
		for (int r = 0; r < 2; r++) begin
			rankState[r] = {pdReq[r], pageOpen_ff[r], srReq[r], odtReq[r]};
		end
	end
endmodule

`default_nettype wire

// file: verification/mctf_throttle_props.sv
// Port-level assertions for the throttle filter.
`timescale 1ns/1ps
`default_nettype none
`include "mctf_defines.svh"

module mctf_throttle_props
	import mctf_pkg::*;
#(
	parameter int NUM_RANKS = 2,
	parameter int TC_BASE   = 28
) (
	input wire logic             clk,
	input wire logic             sys_rst,
	input wire logic             ce,
	input wire logic [11:0]      regAddr,
	input wire logic [31:0]      regWrData,
	input wire logic             regWrEn,
	input wire logic             regRdEn,
	input wire logic [31:0]      regRdData,
	input wire mctf_cmd_s        cmdBus,
	input wire mctf_rank_s [1:0] rankState,
	input wire logic             thermalTrip,
	input wire logic             firstChanRankLock,
	input wire logic             holdCommands
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [31:0] cmdSh;  // Command weights.
	logic [31:0] ctrlSh; // Controller control.
	logic [31:0] pasSh;  // Passive low word.
	logic [31:0] actSh;  // Active low word.
	logic [2:0]  selSh;  // Observation selector.
	logic        rankLk; // Rank lock has been set.

	// Shadow words take a write only while their lock is clear.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmdSh  <= '0;
			ctrlSh <= '0;
			pasSh  <= '0;
			actSh  <= '0;
			selSh  <= '0;
			rankLk <= 1'b0;
		end else if (ce && regWrEn) begin
			if (regAddr == `MCTF_OFS_CMD_WEIGHTS && !ctrlSh[31]) cmdSh <= regWrData;
			if (regAddr == `MCTF_OFS_CTRL_THROTTLE && !ctrlSh[31])
				ctrlSh <= regWrData & `MCTF_CTRL_WMASK;
			if (regAddr == `MCTF_OFS_PASSIVE_LO && !rankLk && !firstChanRankLock)
				pasSh <= regWrData;
			if (regAddr == `MCTF_OFS_ACTIVE_LO && !rankLk) actSh <= regWrData;
			if (regAddr == `MCTF_OFS_OBSERVATION) selSh <= regWrData[18:16];
			if (regAddr == `MCTF_OFS_RANK_THROTTLE) rankLk <= rankLk | regWrData[31];
		end
	end

	sequence rdAt(logic [11:0] a);
		ce && regRdEn && regAddr == a;
	endsequence
	property readBack(logic [11:0] a, logic [31:0] v);
		rdAt(a) |=> regRdData == $past(v);
	endproperty

	a_cmd_wt_lock:
		assert property (readBack(`MCTF_OFS_CMD_WEIGHTS, cmdSh)) else $error("command weights wrong");
	a_passive_lock:
		assert property (readBack(`MCTF_OFS_PASSIVE_LO, pasSh)) else $error("passive word wrong");
	a_active_lock:
		assert property (readBack(`MCTF_OFS_ACTIVE_LO, actSh)) else $error("active word wrong");
	a_obs_fields:
		assert property (rdAt(`MCTF_OFS_OBSERVATION) |=> regRdData[31:16] == {13'h0, $past(selSh)})
		else $error("observation selector wrong");
	a_rdata_quiet:
		assert property (ce && !regRdEn |=> regRdData == 32'h0000_0000) else $error("stray read data");
	a_no_enable_hold:
		assert property (ce && !ctrlSh[21] && !ctrlSh[20] |=> !holdCommands) else $error("hold unasked");
	a_therm_no_trip:
		assert property (ce && ctrlSh[20] && !ctrlSh[21] && !thermalTrip |=> !holdCommands)
		else $error("hold without trip");
	a_bw_zero_thr:
		assert property (ce && ctrlSh[21] && ctrlSh[15:8] == 8'h00 && !(ctrlSh[20] && thermalTrip)
			|=> holdCommands) else $error("bandwidth hold missing");
	a_therm_zero_thr:
		assert property (ce && ctrlSh[20] && thermalTrip && ctrlSh[7:0] == 8'h00 |=> holdCommands)
		else $error("thermal hold missing");

	c_hold_rise: cover property ($rose(holdCommands));
	c_locked_write: cover property (ce && regWrEn && ctrlSh[31]);
	c_obs_read: cover property (rdAt(`MCTF_OFS_OBSERVATION));
endmodule

bind mctf_throttle mctf_throttle_props #(.NUM_RANKS(NUM_RANKS), .TC_BASE(TC_BASE))
	i_mctf_throttle_props (.clk, .sys_rst, .ce, .regAddr, .regWrData, .regWrEn, .regRdEn,
	.regRdData, .cmdBus, .rankState, .thermalTrip, .firstChanRankLock, .holdCommands);

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the channel throttle filter.
`timescale 1ns/1ps
`default_nettype none
`include "mctf_defines.svh"

module tb_top
	import mctf_pkg::*;
;
	localparam int TCB = 2; // Short windows settle quickly.
	// Case bits: bw en, thermal en, trip, hold, bw and thermal threshold codes.
	localparam logic [7:0] THR [10] = '{8'h94, 8'h88, 8'h00, 8'h71, 8'h62, 8'h40, 8'he2,
		8'hf8, 8'h90, 8'hd6};
	logic             clk;
	logic             sys_rst;
	logic             ce;
	logic [11:0]      regAddr;
	logic [31:0]      regWrData;
	logic             regWrEn;
	logic             regRdEn;
	logic [31:0]      regRdData;
	mctf_cmd_s        cmdBus;
	mctf_rank_s [1:0] rankState;
	logic             thermalTrip;
	logic             firstChanRankLock;
	logic             holdCommands;
	logic [1:0]       pdReq;
	logic [1:0]       srReq;
	logic [1:0]       odtReq;
	int               n_fail;
	int               n_compared;
	int               cyc;
	logic [31:0]      cw;    // Command weights.
	logic [31:0]      pasLo; // Passive low word.
	logic [31:0]      pasHi; // Passive high word.
	logic [63:0]      act;   // Active weights.
	logic [31:0]      d;     // Last read data.
	logic [31:0]      v;     // Random write value.
	logic [11:0]      a;     // Register address.
	logic [7:0]       lvl;   // Settled controller average.
	logic [1:0]       tc;    // Time-constant code.

	mctf_throttle #(.TC_BASE(TCB)) i_mctf_throttle (.clk, .sys_rst, .ce, .regAddr, .regWrData,
		.regWrEn, .regRdEn, .regRdData, .cmdBus, .rankState, .thermalTrip, .firstChanRankLock,
		.holdCommands);
	mctf_rank_model i_mctf_rank_model (.clk, .sys_rst, .cmdBus, .pdReq, .srReq, .odtReq,
		.rankState);

	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// A hang counts as a failure.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle write and read; read data stand in the next cycle.
	task automatic wr(input logic [11:0] ad, input logic [31:0] dat);
		@(posedge clk);
		regAddr   <= ad;
		regWrData <= dat;
		regWrEn   <= 1'b1;
		@(posedge clk);
		regWrEn   <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ad);
		@(posedge clk);
		regAddr <= ad;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 d = regRdData;
		@(posedge clk);
	endtask

	// Writable bits of each word.
	function automatic logic [31:0] wm(input logic [11:0] ad);
		case (ad)
			`MCTF_OFS_CTRL_THROTTLE, `MCTF_OFS_RANK_THROTTLE: return `MCTF_CTRL_WMASK;
			`MCTF_OFS_PASSIVE_HI: return `MCTF_PASSIVE_HI_WMASK;
			`MCTF_OFS_OBSERVATION: return 32'h0007_0000;
			12'h1e0: return 32'h0000_0000;
			default: return 32'hffff_ffff;
		endcase
	endfunction

	// Controller weight of the present command.
	function automatic logic [7:0] ctrlW();
		if (!cmdBus.valid) return cw[7:0];
		case (cmdBus.kind)
			CMD_RD, CMD_RD_AP: return cw[31:24];
			CMD_WR, CMD_WR_AP: return cw[23:16];
			default: return cw[15:8];
		endcase
	endfunction

	// Rank weight: state, termination and command shares.
	function automatic logic [9:0] rankW(input int r);
		mctf_rank_s s;
		logic [9:0] w;
		s = rankState[r];
		if (s.selfRefresh) w = 10'(pasLo[7:0]);
		else if (s.powerDown) w = 10'(s.pageOpen ? pasLo[23:16] : pasLo[15:8]);
		else w = 10'(s.pageOpen ? pasHi[7:0] : pasLo[31:24]);
		if (s.odt) w = w + 10'(pasHi[15:8]);
		if (cmdBus.valid && cmdBus.chipSel[r] && cmdBus.kind != CMD_OTHER)
			w = w + 10'(act[(7 - int'(cmdBus.kind)) * 8 +: 8]);
		return w;
	endfunction

	function automatic logic [7:0] thr(input logic [1:0] c);
		return (c == 2'd0) ? 8'h00 : ((c == 2'd1) ? lvl : lvl + 8'h01);
	endfunction

	initial begin
		{sys_rst, ce} = 2'b11;
		{regAddr, regWrData, regWrEn, regRdEn} = '0;
		{cmdBus, thermalTrip, firstChanRankLock, pdReq, srReq, odtReq} = '0;
		{n_fail, n_compared, cyc} = '0;
		d = $urandom(32'he6e6_1a31);
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset values; a zero average meets both zero thresholds.
		for (int i = 0; i < 9; i++) begin
			rd(`MCTF_OFS_CMD_WEIGHTS + 12'(4 * i));
			chk(d, (i == 7) ? 32'h0000_0006 : `MCTF_RST_WORD);
		end
		$display("test reset_values finished");
		// Random values read back through the write masks.
		for (int i = 0; i < 9; i++) begin
			a = `MCTF_OFS_CMD_WEIGHTS + 12'(4 * i);
			v = $urandom & 32'h7fff_ffff;
			wr(a, v);
			rd(a);
			chk((a == `MCTF_OFS_OBSERVATION) ? d & 32'h0007_0000 : d, v & wm(a));
		end
		$display("test readback finished");
		cw = $urandom;
		pasLo = $urandom & 32'h3f3f_3f3f;
		pasHi = $urandom & 32'h0000_3f3f;
		act = {$urandom & 32'h3f3f_3f3f, $urandom & 32'h3f3f_3f3f};
		wr(`MCTF_OFS_CMD_WEIGHTS, cw);
		wr(`MCTF_OFS_CTRL_THROTTLE, 32'h0000_0000);
		wr(`MCTF_OFS_PASSIVE_LO, pasLo);
		wr(`MCTF_OFS_PASSIVE_HI, pasHi);
		wr(`MCTF_OFS_ACTIVE_LO, act[31:0]);
		wr(`MCTF_OFS_ACTIVE_HI, act[63:32]);
		// Every command kind; both averages settle on their weights.
		for (int i = 0; i < 18; i++) begin
			tc = 2'($urandom);
			wr(`MCTF_OFS_RANK_THROTTLE, {14'h0, tc, 16'h0});
			cmdBus.valid <= (i < 9) || ($urandom % 2 == 0);
			cmdBus.kind <= mctf_cmd_e'(4'(i % 9));
			cmdBus.chipSel <= 2'($urandom);
			pdReq <= 2'($urandom);
			srReq <= 2'($urandom) & 2'($urandom);
			odtReq <= 2'($urandom);
			repeat (48 << tc) @(posedge clk);
			wr(`MCTF_OFS_OBSERVATION, 32'h0000_0000);
			rd(`MCTF_OFS_OBSERVATION);
			chk(32'(d[15:8]), 32'(ctrlW()));
			wr(`MCTF_OFS_OBSERVATION, {13'h0, 3'((i % 2) + 1), 16'h0});
			rd(`MCTF_OFS_OBSERVATION);
			chk(32'(d[15:8]), 32'(rankW(i % 2)));
		end
		wr(`MCTF_OFS_OBSERVATION, 32'h0005_0000);
		rd(`MCTF_OFS_OBSERVATION);
		chk(32'(d[15:8]), 32'h0000_0000);
		$display("test filter_weights finished");
		// Threshold cases around a settled average.
		lvl = 8'h20 + 8'($urandom_range(191));
		cw[7:0] = lvl;
		wr(`MCTF_OFS_CMD_WEIGHTS, cw);
		wr(`MCTF_OFS_RANK_THROTTLE, 32'h0000_0000);
		cmdBus.valid <= 1'b0;
		repeat (64) @(posedge clk);
		foreach (THR[k]) begin
			thermalTrip <= THR[k][5];
			wr(`MCTF_OFS_CTRL_THROTTLE, {10'h0, THR[k][7:6], 4'h0, thr(THR[k][3:2]), thr(THR[k][1:0])});
			repeat (3) @(posedge clk);
			#1 chk(32'(holdCommands), 32'(THR[k][4]));
			rd(`MCTF_OFS_OBSERVATION);
			chk(32'(d[0]), 32'(THR[k][4]));
		end
		thermalTrip <= 1'b0;
		$display("test thresholds finished");
		// Locks, and a write while the clock enable is low.
		firstChanRankLock <= 1'b1;
		wr(`MCTF_OFS_PASSIVE_LO, ~pasLo);
		firstChanRankLock <= 1'b0;
		rd(`MCTF_OFS_PASSIVE_LO);
		chk(d, pasLo);
		ce <= 1'b0;
		wr(`MCTF_OFS_CMD_WEIGHTS, ~cw);
		ce <= 1'b1;
		rd(`MCTF_OFS_CMD_WEIGHTS);
		chk(d, cw);
		wr(`MCTF_OFS_CTRL_THROTTLE, 32'h8000_0000 | 32'(lvl));
		wr(`MCTF_OFS_CMD_WEIGHTS, ~cw);
		wr(`MCTF_OFS_CTRL_THROTTLE, 32'h0000_0000);
		rd(`MCTF_OFS_CMD_WEIGHTS);
		chk(d, cw);
		rd(`MCTF_OFS_CTRL_THROTTLE);
		chk(d, 32'h8000_0000 | 32'(lvl));
		wr(`MCTF_OFS_RANK_THROTTLE, 32'h8000_0000);
		wr(`MCTF_OFS_ACTIVE_LO, ~act[31:0]);
		wr(`MCTF_OFS_PASSIVE_HI, ~pasHi);
		wr(`MCTF_OFS_RANK_THROTTLE, 32'h0000_0000);
		rd(`MCTF_OFS_ACTIVE_LO);
		chk(d, act[31:0]);
		rd(`MCTF_OFS_PASSIVE_HI);
		chk(d, pasHi);
		rd(`MCTF_OFS_RANK_THROTTLE);
		chk(d, 32'h8000_0000);
		// A second reset clears both locks.
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`MCTF_OFS_CTRL_THROTTLE);
		chk(d, 32'h0000_0000);
		rd(`MCTF_OFS_RANK_THROTTLE);
		chk(d, 32'h0000_0000);
		$display("test locks finished");
		complete_run();
	end
endmodule

`default_nettype wire
